// ==== src/omsel_top.sv ====
// Behaviour
// - Order: selection, stop, term/remote, panel/remote, panel/term, startup.
// - Recompute mode from both settings at power-up, power restore and reset.
// - Startup 0, selection 0: terminal start, any switch but panel-remote.
// - Selection 1: start in panel mode, never change.
// - Startup 0, selection 2: terminal start, terminal/remote only, no panel.
// - Selection 3 or 4: combined mode, never change.
// - Startup 0, selection 6: terminal start, may switch while running.
// - Startup 0, selection 7: terminal start; stop off forces terminal, on frees it.
// - Startup 1, selection 0, 2, 6: remote start, switching as startup 0.
// - Startup 1, selection 7: remote if stop input on, else terminal.
// - Startup 10, selection 0: start remote, panel/remote switching only.
// - Startup 10, selection 2: remote mode held, no changes.
// - Startup 10, selection 6: remote start, panel/remote while running.
// - Startup 10, selection 1, 3, 4, 7: behave as startup 0.
// - General switching never goes directly between panel and remote.
// - Panel/remote switching follows panel key or panel/remote input.
// - Setting writes accepted only while stopped.
// - Startup setting writable only when extended display setting is 0.
// - In remote mode the remote program gets writes and run commands.
// - Combined, selection 4: run from panel key, speed from potentiometer.
// - Panel/remote input on selects panel, off selects remote.
// - Terminal/remote input on selects remote, off selects terminal.
// - Otherwise panel/terminal input off selects panel, on selects terminal.
// - Except selection 6, switch-driven transitions only while stopped.
`timescale 1ns/1ps
`default_nettype none
`include "omsel_consts.svh"

module omsel_top
    import omsel_pkg::*;
(
    input  wire logic                  mclk_in,          // 20 MHz clock
    input  wire logic                  rstn_in,          // Power-up, low
    input  wire logic                  power_restore_in, // Power back pulse
    input  wire logic                  unit_reset_in,    // Unit reset pulse
    input  wire logic                  motor_running_in, // Motor turning
    input  wire logic                  start_cmd_in,     // Start command on
    input  wire logic [`OMS_SET_W-1:0] extended_display_setting_in, // Ext disp
    input  wire logic [`OMS_ASG_W-1:0] input_terminal_assign_settings_in,
    input  wire logic                  setting_wr_in,    // Write strobe
    input  wire logic                  setting_wr_addr_in, // 0 sel, 1 startup
    input  wire logic [`OMS_SET_W-1:0] setting_wr_data_in, // Write value
    input  wire logic                  output_stop_input_in,   // Pin
    input  wire logic                  panel_remote_switch_input_in, // Pin
    input  wire logic                  terminal_remote_switch_input_in, // Pin
    input  wire logic                  panel_terminal_switch_input_in, // Pin
    input  wire logic                  panel_mode_key_in, // Panel key pin
    output logic      [3:0]            mode_out,         // One-hot mode
    output logic      [`OMS_SET_W-1:0] mode_selection_setting_out, // Stored
    output logic      [`OMS_SET_W-1:0] startup_mode_setting_out,   // Stored
    output logic                       setting_wr_ack_out,    // Write taken
    output logic                       setting_wr_reject_out, // Write refused
    output logic                       remote_cmd_enable_out, // Remote owns
    output logic                       panel_run_source_out,  // Run from key
    output logic                       pot_speed_source_out   // Speed from pot
);

    // Legal mode selection values
    function automatic logic sel_valid(input logic [`OMS_SET_W-1:0] v);
        return (v <= `OMS_SEL_COMB2) || (v == `OMS_SEL_RUNSW) ||
               (v == `OMS_SEL_STOPGATE);
    endfunction

    // Legal startup values
    function automatic logic st_valid(input logic [`OMS_SET_W-1:0] v);
        return (v == `OMS_ST_ASSEL) || (v == `OMS_ST_REMOTE) ||
               (v == `OMS_ST_PANREM);
    endfunction

    // Mode chosen at power-up, restore or reset
    function automatic omsel_mode_t init_mode(
        input logic [`OMS_SET_W-1:0] sel,
        input logic [`OMS_SET_W-1:0] stv,
        input logic                  stop
    );
        omsel_mode_t m;
        m = OMS_TERM;
        case (sel)
            `OMS_SEL_PANEL: begin
                m = OMS_PANEL;
            end
            `OMS_SEL_COMB1, `OMS_SEL_COMB2: begin
                m = OMS_COMB;
            end
            `OMS_SEL_STOPGATE: begin
                // Startup 10 falls back to startup 0 here
                m = (stv == `OMS_ST_REMOTE && stop) ? OMS_REMOTE
                                                    : OMS_TERM;
            end
            default: begin
                // Selections 0, 2, 6
                m = (stv == `OMS_ST_ASSEL) ? OMS_TERM
                                           : OMS_REMOTE;
            end
        endcase
        return m;
    endfunction

    // Held-mode cases that ignore every switch input
    function automatic logic is_fixed(
        input logic [`OMS_SET_W-1:0] sel,
        input logic [`OMS_SET_W-1:0] stv,
        input logic                  stop
    );
        return (sel == `OMS_SEL_PANEL) || (sel == `OMS_SEL_COMB1) ||
               (sel == `OMS_SEL_COMB2) ||
               (sel == `OMS_SEL_STOPGATE && !stop) ||
               (sel == `OMS_SEL_TERM && stv == `OMS_ST_PANREM);
    endfunction

    // Mode that a held case pins the selector to
    function automatic omsel_mode_t fixed_mode(
        input logic [`OMS_SET_W-1:0] sel
    );
        omsel_mode_t m;
        case (sel)
            `OMS_SEL_PANEL:                m = OMS_PANEL;
            `OMS_SEL_COMB1, `OMS_SEL_COMB2: m = OMS_COMB;
            `OMS_SEL_STOPGATE:             m = OMS_TERM;
            default:                       m = OMS_REMOTE;
        endcase
        return m;
    endfunction

    // Switch target from inputs in precedence order
    function automatic omsel_mode_t switch_target(
        input omsel_mode_t                 cur,
        input logic [`OMS_SET_W-1:0]       sel,
        input logic [`OMS_SET_W-1:0]       stv,
        input omsel_pins_t                 p,
        input logic [`OMS_ASG_W-1:0]       asg,
        input logic                        key_rise
    );
        omsel_mode_t t;
        t = cur;
        if (stv == `OMS_ST_PANREM &&
            (sel == `OMS_SEL_SWITCH || sel == `OMS_SEL_RUNSW)) begin
            // Panel/remote pair only
            if (asg[`OMS_ASG_TR] && p.terminal_remote) begin
                t = OMS_REMOTE;
            end else if (asg[`OMS_ASG_PR]) begin
                t = p.panel_remote ? OMS_PANEL : OMS_REMOTE;
            end else if (key_rise) begin
                t = (cur == OMS_PANEL) ? OMS_REMOTE : OMS_PANEL;
            end
        end else begin
            // General rule, startup 0 or 1 or fallback
            if (asg[`OMS_ASG_TR] && p.terminal_remote) begin
                t = OMS_REMOTE;
            end else if (asg[`OMS_ASG_TR] && cur == OMS_REMOTE) begin
                t = OMS_TERM;
            end else if (asg[`OMS_ASG_PT]) begin
                t = p.panel_terminal ? OMS_TERM : OMS_PANEL;
            end else if (key_rise && cur != OMS_REMOTE) begin
                t = (cur == OMS_PANEL) ? OMS_TERM : OMS_PANEL;
            end
            if (sel == `OMS_SEL_TERM && t == OMS_PANEL) begin
                t = cur;
            end
            // A direct jump would bypass terminal mode
            if ((cur == OMS_PANEL && t == OMS_REMOTE) ||
                (cur == OMS_REMOTE && t == OMS_PANEL)) begin
                t = cur;
            end
        end
        return t;
    endfunction

    omsel_state_t s_r;
    omsel_state_t s_nxt;
    omsel_pins_t  pins;
    logic [`OMS_PIN_W-1:0] pins_raw;
    logic [`OMS_PIN_W-1:0] pins_sync;
    logic         stopped;
    logic         key_rise;
    logic         eval_now;
    logic         wr_ok;
    logic         may_switch;
    omsel_mode_t  tgt;

    // Pins cross into the clock domain
    assign pins_raw = {output_stop_input_in,
                       panel_remote_switch_input_in,
                       terminal_remote_switch_input_in,
                       panel_terminal_switch_input_in,
                       panel_mode_key_in};

    omsel_sync #(
        .W       (`OMS_PIN_W)
    ) u_sync (
        .mclk_in (mclk_in),
        .rstn_in (rstn_in),
        .d_in    (pins_raw),
        .q_out   (pins_sync)
    );

    assign pins = omsel_pins_t'(pins_sync);

    // Stop means motor still or start command off
    assign stopped  = !motor_running_in || !start_cmd_in;
    assign key_rise = pins.panel_key && !s_r.key_d;
    assign eval_now = s_r.eval_pend || power_restore_in || unit_reset_in;

    // Write permission check
    assign wr_ok = stopped &&
                   ((setting_wr_addr_in == `OMS_WA_SEL) ?
                    sel_valid(setting_wr_data_in) :
                    (extended_display_setting_in == `OMS_EXT_OPEN &&
                     st_valid(setting_wr_data_in)));

    // Selection 6 is the only one that switches while running
    assign may_switch = stopped ||
                        (s_r.act_sel == `OMS_SEL_RUNSW);
    assign tgt = switch_target(s_r.mode, s_r.act_sel, s_r.act_st, pins,
                               input_terminal_assign_settings_in, key_rise);

    // Next state; new settings only act after the next evaluation
    always_comb begin
        s_nxt        = s_r;
        s_nxt.key_d  = pins.panel_key;
        s_nxt.wr_ack = 1'b0;
        s_nxt.wr_rej = 1'b0;
        if (setting_wr_in) begin
            if (wr_ok) begin
                s_nxt.wr_ack = 1'b1;
                if (setting_wr_addr_in == `OMS_WA_SEL) begin
                    s_nxt.sel = setting_wr_data_in;
                end else begin
                    s_nxt.st = setting_wr_data_in;
                end
            end else begin
                s_nxt.wr_rej = 1'b1;
            end
        end
        if (eval_now) begin
            s_nxt.eval_pend = 1'b0;
            s_nxt.act_sel   = s_r.sel;
            s_nxt.act_st    = s_r.st;
            s_nxt.mode      = init_mode(s_r.sel, s_r.st,
                                        pins.output_stop);
        end else if (is_fixed(s_r.act_sel, s_r.act_st,
                              pins.output_stop)) begin
            s_nxt.mode = fixed_mode(s_r.act_sel);
        end else if (may_switch) begin
            s_nxt.mode = tgt;
        end
        s_nxt.remote_cmd = (s_nxt.mode == OMS_REMOTE);
        s_nxt.panel_run  = (s_nxt.mode == OMS_COMB) &&
                           (s_nxt.act_sel == `OMS_SEL_COMB2);
        s_nxt.pot_speed  = s_nxt.panel_run;
    end

    // Power-up leaves an evaluation pending
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            s_r            <= '0;
            s_r.mode       <= OMS_TERM;
            s_r.sel        <= `OMS_SEL_RST;
            s_r.st         <= `OMS_ST_RST;
            s_r.act_sel    <= `OMS_SEL_RST;
            s_r.act_st     <= `OMS_ST_RST;
            s_r.eval_pend  <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Every output straight from the state register
    assign mode_out                   = s_r.mode;
    assign mode_selection_setting_out = s_r.sel;
    assign startup_mode_setting_out   = s_r.st;
    assign setting_wr_ack_out         = s_r.wr_ack;
    assign setting_wr_reject_out      = s_r.wr_rej;
    assign remote_cmd_enable_out      = s_r.remote_cmd;
    assign panel_run_source_out       = s_r.panel_run;
    assign pot_speed_source_out       = s_r.pot_speed;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rstn_in);

    // Held modes, switching limits, write gating, re-evaluation and remote enable
    a_sel1_panel_hold: assert property (
        !s_r.eval_pend && s_r.act_sel == `OMS_SEL_PANEL
        |-> s_r.mode == OMS_PANEL)
        else $error("selection 1 left panel mode");

    a_comb_mode_hold: assert property (
        !s_r.eval_pend && (s_r.act_sel == `OMS_SEL_COMB1 ||
                           s_r.act_sel == `OMS_SEL_COMB2)
        |-> s_r.mode == OMS_COMB)
        else $error("combined mode not held");

    a_stop_forces_term: assert property (
        !eval_now && s_r.act_sel == `OMS_SEL_STOPGATE && !pins.output_stop
        |=> s_r.mode == OMS_TERM)
        else $error("stop off did not force terminal mode");

    a_remote_fixed_hold: assert property (
        !s_r.eval_pend && s_r.act_sel == `OMS_SEL_TERM &&
        s_r.act_st == `OMS_ST_PANREM
        |-> s_r.mode == OMS_REMOTE)
        else $error("remote mode not held");

    a_sel2_no_panel: assert property (
        !s_r.eval_pend && s_r.act_sel == `OMS_SEL_TERM
        |-> s_r.mode != OMS_PANEL)
        else $error("selection 2 entered panel mode");

    a_no_direct_jump: assert property (
        !eval_now && s_r.act_st != `OMS_ST_PANREM &&
        s_r.mode == OMS_PANEL
        |=> s_r.mode != OMS_REMOTE)
        else $error("direct panel to remote change");

    a_run_mode_frozen: assert property (
        !eval_now && !stopped && s_r.act_sel != `OMS_SEL_RUNSW &&
        !is_fixed(s_r.act_sel, s_r.act_st, pins.output_stop)
        |=> $stable(s_r.mode))
        else $error("mode changed while running");

    a_write_when_stop: assert property (
        setting_wr_ack_out |-> $past(stopped) && $past(setting_wr_in))
        else $error("setting write taken while running");

    a_startup_ext_gate: assert property (
        setting_wr_ack_out && $past(setting_wr_addr_in) == `OMS_WA_ST
        |-> $past(extended_display_setting_in) == `OMS_EXT_OPEN)
        else $error("startup write with display gate closed");

    a_restore_reeval: assert property (
        power_restore_in && s_r.sel == `OMS_SEL_PANEL
        |=> s_r.mode == OMS_PANEL ##1 s_r.mode == OMS_PANEL)
        else $error("restore did not re-evaluate mode");

    a_remote_cmd_tie: assert property (
        remote_cmd_enable_out == (s_r.mode == OMS_REMOTE))
        else $error("remote command enable out of step");

    // Main scenarios
    c_into_remote: cover property (
        s_r.mode == OMS_TERM ##1 s_r.mode == OMS_REMOTE);
    c_panel_remote: cover property (
        s_r.mode == OMS_PANEL ##1 s_r.mode == OMS_REMOTE);
    c_forced_term: cover property (
        s_r.act_sel == `OMS_SEL_STOPGATE && s_r.mode == OMS_PANEL
        ##1 s_r.mode == OMS_TERM);
    c_write_reject: cover property (setting_wr_reject_out);

endmodule // omsel_top

`default_nettype wire

// ==== src/omsel_consts.svh ====
`ifndef OMSEL_CONSTS_SVH
`define OMSEL_CONSTS_SVH

// Width of a setting value
`define OMS_SET_W        8

// Mode selection setting values
`define OMS_SEL_SWITCH   8'h00
`define OMS_SEL_PANEL    8'h01
`define OMS_SEL_TERM     8'h02
`define OMS_SEL_COMB1    8'h03
`define OMS_SEL_COMB2    8'h04
`define OMS_SEL_RUNSW    8'h06
`define OMS_SEL_STOPGATE 8'h07

// Startup mode setting values
`define OMS_ST_ASSEL     8'h00
`define OMS_ST_REMOTE    8'h01
`define OMS_ST_PANREM    8'h0A

// Extended display value that opens startup writes
`define OMS_EXT_OPEN     8'h00

// Reset values of the two settings
`define OMS_SEL_RST      8'h00
`define OMS_ST_RST       8'h00

// Setting write address
`define OMS_WA_SEL       1'b0
`define OMS_WA_ST        1'b1

// Bit positions in the terminal assignment vector
`define OMS_ASG_PR       0
`define OMS_ASG_TR       1
`define OMS_ASG_PT       2
`define OMS_ASG_W        3

// Number of synchronised pins
`define OMS_PIN_W        5

`endif

// ==== src/omsel_pkg.sv ====
package omsel_pkg;

`include "omsel_consts.svh"

    // Operating mode, one-hot
    typedef enum logic [3:0] {
        OMS_TERM   = 4'b0001,
        OMS_PANEL  = 4'b0010,
        OMS_REMOTE = 4'b0100,
        OMS_COMB   = 4'b1000
    } omsel_mode_t;

    // Synchronised switch pins
    typedef struct packed {
        logic output_stop;
        logic panel_remote;
        logic terminal_remote;
        logic panel_terminal;
        logic panel_key;
    } omsel_pins_t;

    // Whole state of the selector
    typedef struct packed {
        omsel_mode_t             mode;
        logic [`OMS_SET_W-1:0]   sel;
        logic [`OMS_SET_W-1:0]   st;
        logic [`OMS_SET_W-1:0]   act_sel;
        logic [`OMS_SET_W-1:0]   act_st;
        logic                    eval_pend;
        logic                    key_d;
        logic                    wr_ack;
        logic                    wr_rej;
        logic                    remote_cmd;
        logic                    panel_run;
        logic                    pot_speed;
    } omsel_state_t;

endpackage

// ==== src/omsel_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module omsel_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk_in,  // Clock
    input  wire logic         rstn_in,  // Sync reset, low
    input  wire logic [W-1:0] d_in,     // Asynchronous levels
    output logic      [W-1:0] q_out     // Synchronised levels
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } omsel_sync_st_t;

    omsel_sync_st_t s_r;
    omsel_sync_st_t s_nxt;

    // Meta stage feeds only the second stage
    always_comb begin
        s_nxt      = s_r;
        s_nxt.meta = d_in;
        s_nxt.sync = s_r.meta;
    end

    // Both stages on every rising edge
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q_out = s_r.sync;

endmodule // omsel_sync

`default_nettype wire

// ==== tb/omsel_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "omsel_consts.svh"

module omsel_host_model
    import omsel_pkg::*;
(
    input  wire logic                  mclk_in,  // Clock
    output logic                       wr_out,   // Write strobe
    output logic                       addr_out, // Setting address
    output logic      [`OMS_SET_W-1:0] data_out, // Write value
    output var omsel_pins_t            pins_out  // Terminal and key pins
);
    // Idle host, all pins off
    initial begin
        wr_out   = 1'b0;
        addr_out = 1'b0;
        data_out = 8'h00;
        pins_out = '0;
    end

    // One write over one edge; refused while running
    task automatic put(input logic a, input logic [`OMS_SET_W-1:0] d);
        @(negedge mclk_in);
        wr_out   = 1'b1;
        addr_out = a;
        data_out = d;
        @(negedge mclk_in);
        wr_out   = 1'b0;
        data_out = ~d;  // Released bus must not look valid
    endtask

    // Pin levels move off the sampling edge
    task automatic set_pins(input omsel_pins_t p);
        @(negedge mclk_in);
        pins_out = p;
    endtask
endmodule // omsel_host_model
`default_nettype wire

// ==== tb/omsel_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "omsel_consts.svh"

module omsel_tb
    import omsel_pkg::*;
;
    localparam logic [7:0] MT = 8'(OMS_TERM);
    localparam logic [7:0] MP = 8'(OMS_PANEL);
    localparam logic [7:0] MR = 8'(OMS_REMOTE);
    localparam logic [7:0] MC = 8'(OMS_COMB);
    logic        mclk_in = 1'b0;
    logic        rstn_in, pwr, urst, run, start, wr, wa;
    logic        ack, rej, rce, prs, pss;
    logic [7:0]  terminal_control_mode, wd, sel_o, st_o, e;
    logic [2:0]  asg;
    logic [3:0]  mode;
    omsel_pins_t pins;
    int          bad_count = 0;
    int          n_compared = 0;
    int          k;
    logic [7:0]  sels [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07};
    logic [7:0]  sts [3] = '{8'h00, 8'h01, 8'h0A};

    // 20 MHz clock
    always #25 mclk_in = ~mclk_in;

    omsel_host_model host (.mclk_in(mclk_in), .wr_out(wr), .addr_out(wa),
        .data_out(wd), .pins_out(pins));

    omsel_top dut (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .power_restore_in(pwr), .unit_reset_in(urst),
        .motor_running_in(run), .start_cmd_in(start),
        .extended_display_setting_in(terminal_control_mode),
        .input_terminal_assign_settings_in(asg),
        .setting_wr_in(wr), .setting_wr_addr_in(wa), .setting_wr_data_in(wd),
        .output_stop_input_in(pins.output_stop),
        .panel_remote_switch_input_in(pins.panel_remote),
        .terminal_remote_switch_input_in(pins.terminal_remote),
        .panel_terminal_switch_input_in(pins.panel_terminal),
        .panel_mode_key_in(pins.panel_key), .mode_out(mode),
        .mode_selection_setting_out(sel_o), .startup_mode_setting_out(st_o),
        .setting_wr_ack_out(ack), .setting_wr_reject_out(rej),
        .remote_cmd_enable_out(rce), .panel_run_source_out(prs),
        .pot_speed_source_out(pss));

    task automatic end_of_test();
        if (bad_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Mode expected right after an evaluation
    function automatic logic [7:0] exp_init(input logic [7:0] s,
                                            input logic [7:0] t,
                                            input logic stop);
        if (t == 8'h0A &&
            (s == 8'h01 || s == 8'h03 || s == 8'h04 || s == 8'h07))
            t = 8'h00;
        case (s)
            8'h01:        return MP;
            8'h03, 8'h04: return MC;
            8'h07:        return (t == 8'h01 && stop) ? MR : MT;
            default:      return (t == 8'h00) ? MT : MR;
        endcase
    endfunction

    // Whether a write should be taken
    function automatic logic wr_ok(input logic a, input logic [7:0] d);
        if (run && start)
            return 1'b0;
        if (a)
            return (d == 8'h00 || d == 8'h01 || d == 8'h0A) && terminal_control_mode == 8'h00;
        return d <= 8'h04 || d == 8'h06 || d == 8'h07;
    endfunction

    task automatic wr_chk(input logic a, input logic [7:0] d);
        logic       ok;
        logic [7:0] old;
        ok  = wr_ok(a, d);
        old = a ? st_o : sel_o;
        host.put(a, d);
        check(8'(ack), 8'(ok));
        check(8'(rej), 8'(!ok));
        check(a ? st_o : sel_o, ok ? d : old);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk_in);
    endtask

    // Either re-evaluation source, picked at random
    task automatic eval();
        @(negedge mclk_in);
        if ($urandom % 2)
            pwr = 1'b1;
        else
            urst = 1'b1;
        @(negedge mclk_in);
        pwr  = 1'b0;
        urst = 1'b0;
    endtask

    // Store settings while stopped, settle stop pin, re-evaluate
    task automatic cfg(input logic [7:0] s, input logic [7:0] t,
                       input logic stop);
        run   = 1'b0;
        start = 1'b0;
        terminal_control_mode   = 8'h00;
        host.put(1'b0, s);
        host.put(1'b1, t);
        host.set_pins(omsel_pins_t'({stop, 4'h0}));
        wait_n(3);
        eval();
        e = exp_init(s, t, stop);
        check({4'h0, mode}, e);
    endtask

    // Pins reach the mode three edges later; allow four
    task automatic step(input logic [4:0] p, input logic [7:0] m);
        host.set_pins(omsel_pins_t'(p));
        wait_n(4);
        check({4'h0, mode}, m);
    endtask

    // Main sequence
    initial begin
        {rstn_in, pwr, urst, run, start} = 5'h00;
        terminal_control_mode = 8'h00;
        asg = 3'b000;
        void'($urandom(58226));
        wait_n(4);
        rstn_in = 1'b1;
        wait_n(2);
        check({4'h0, mode}, MT);
        terminal_control_mode = 8'(1 + $urandom % 255);
        wr_chk(1'b1, 8'h01);
        terminal_control_mode = 8'h00;
        run = 1'b1;
        start = 1'b1;
        wr_chk(1'b0, 8'h02);
        start = 1'b0;
        wr_chk(1'b0, 8'h02);
        run = 1'b0;
        wr_chk(1'b0, 8'h05);
        wr_chk(1'b1, 8'h02);
        repeat (24) begin
            run   = 1'($urandom);
            start = 1'($urandom);
            terminal_control_mode   = ($urandom % 4 == 0) ? 8'h01 : 8'h00;
            wr_chk(1'($urandom), 8'($urandom % 12));
        end
        // Every selection, startup value and stop level, no switching
        foreach (sels[i]) foreach (sts[j]) for (k = 0; k < 2; k++) begin
            cfg(sels[i], sts[j], k[0]);
            check(8'(rce), 8'(e == MR));
            check(8'(prs), 8'(e == MC && sels[i] == 8'h04));
            check(8'(pss), 8'(e == MC && sels[i] == 8'h04));
        end
        // Panel/terminal input, precedence and no direct panel-remote move
        asg = 3'b100;
        cfg(8'h02, 8'h00, 1'b0);
        step(5'b00000, MT);
        cfg(8'h00, 8'h00, 1'b0);
        step(5'b00000, MP);
        asg = 3'b110;
        step(5'b00100, MP);
        step(5'b00010, MT);
        step(5'b00110, MR);
        step(5'b00010, MT);
        // Running gate, lifted only by selection 6
        asg = 3'b010;
        cfg(8'h00, 8'h00, 1'b0);
        {run, start} = 2'b11;
        step(5'b00100, MT);
        cfg(8'h06, 8'h00, 1'b0);
        {run, start} = 2'b11;
        step(5'b00100, MR);
        // Startup 10: panel/remote input, then key toggling
        asg = 3'b001;
        cfg(8'h00, 8'h0A, 1'b0);
        step(5'b01000, MP);
        step(5'b00000, MR);
        asg = 3'b000;
        step(5'b00001, MP);
        step(5'b00000, MP);
        step(5'b00001, MR);
        asg = 3'b001;
        cfg(8'h02, 8'h0A, 1'b0);
        step(5'b01000, MR);
        cfg(8'h06, 8'h0A, 1'b0);
        {run, start} = 2'b11;
        step(5'b01000, MP);
        // Fixed modes and the stop-gated selection
        asg = 3'b010;
        cfg(8'h01, 8'h00, 1'b0);
        step(5'b00100, MP);
        cfg(8'h04, 8'h00, 1'b0);
        step(5'b00100, MC);
        cfg(8'h07, 8'h01, 1'b1);
        step(5'b00000, MT);
        step(5'b10100, MR);
        // Second reset in mid-run clears settings and mode
        rstn_in = 1'b0;
        wait_n(2);
        rstn_in = 1'b1;
        wait_n(2);
        check({4'h0, mode}, MT);
        check(sel_o, 8'h00);
        end_of_test();
    end

    // Watchdog, well past the expected run length
    initial begin
        #(50 * 8000);
        bad_count++;
        end_of_test();
    end
endmodule // omsel_tb
`default_nettype wire
